//--- verilog/rtcev_regs.svh
// register map, field positions, reset values and timing counts of the rtc event block
// assumes a 32-bit axi4-lite slave with one aligned word per register index
`ifndef RTCEV_REGS_SVH
`define RTCEV_REGS_SVH

// register indices, byte address is four times the index
`define RTCEV_IDX_SEC      6'h00
`define RTCEV_IDX_SEC_ALM  6'h01
`define RTCEV_IDX_MIN      6'h02
`define RTCEV_IDX_MIN_ALM  6'h03
`define RTCEV_IDX_HOUR     6'h04
`define RTCEV_IDX_HOUR_ALM 6'h05
`define RTCEV_IDX_A        6'h0a
`define RTCEV_IDX_B        6'h0b
`define RTCEV_IDX_C        6'h0c
`define RTCEV_IDX_D        6'h0d

// rate and oscillator register fields
`define RTCEV_A_BUSY       7
`define RTCEV_A_OSC_HI     6
`define RTCEV_A_OSC_LO     4
`define RTCEV_A_RATE_HI    3
// control register fields
`define RTCEV_B_INHIBIT    7
`define RTCEV_B_PER_EN     6
`define RTCEV_B_ALM_EN     5
`define RTCEV_B_UPD_EN     4
`define RTCEV_B_SQ_EN      3
// event status fields
`define RTCEV_C_SUM        7
`define RTCEV_C_PER        6
`define RTCEV_C_ALM        5
`define RTCEV_C_UPD        4

// oscillator control codes
`define RTCEV_OSC_RUN      3'b010
`define RTCEV_OSC_RUN_RW   3'b011
`define RTCEV_OSC_HOLD     2'b11

// reset values
`define RTCEV_A_RST        7'h00
`define RTCEV_B_RST        8'h00
`define RTCEV_D_VAL        8'h80
`define RTCEV_ALM_RST      8'h00

// alarm wildcard pattern in the two top bits
`define RTCEV_WILD         2'b11

// axi responses
`define RTCEV_RESP_OKAY    2'b00
`define RTCEV_RESP_SLVERR  2'b10

// timing, in time-base ticks of the 32.768 khz source
`define RTCEV_TB_HZ        32768
`define RTCEV_PRE_UPD_US   244
`define RTCEV_PRE_UPD_TICKS ((`RTCEV_PRE_UPD_US * `RTCEV_TB_HZ + 999999) / 1000000)
`define RTCEV_UPD_LEN_US   1984
`define RTCEV_UPD_LEN_TICKS ((`RTCEV_UPD_LEN_US * `RTCEV_TB_HZ) / 1000000)

`endif

//--- verilog/rtcev_pkg.sv
// types shared by the rtc event block
// assumes nothing beyond a systemverilog compiler
package rtcev_pkg;
   // divider operating mode decoded from the oscillator control field
   typedef enum logic [1:0] {
      rtcev_div_stop = 2'b00,
      rtcev_div_run  = 2'b01,
      rtcev_div_hold = 2'b10
   } rtcev_div_mode_t;

   typedef logic [7:0] rtcev_byte_t;
   typedef logic [3:0] rtcev_rate_t;
endpackage : rtcev_pkg

//--- verilog/rtcev_divider.sv
// divider chain of the rtc time base
// assumes osc_tick is a one-cycle pulse per time-base period, synchronous to aclk
`timescale 1ns/1ps

module rtcev_divider #(
   parameter int DIV_W = 15
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic                     ce,
   input  wire logic                     osc_tick,
   input  wire rtcev_pkg::rtcev_div_mode_t div_mode,
   output logic [DIV_W-1:0]              div_count,
   output logic                          sec_tick
);
   import rtcev_pkg::*;

   logic [DIV_W-1:0] cnt_ff;
   logic             sec_ff;

   ///////////////////////////////////////////////////////////////////////////
   // chain counter: hold clears it, stop freezes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
      end else if (ce) begin
         if (div_mode == rtcev_div_hold) begin
            cnt_ff <= '0;
         end else if (div_mode == rtcev_div_run && osc_tick) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   // one pulse per wrap of the chain, the 1 hz update tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_ff <= 1'b0;
      end else if (ce) begin
         sec_ff <= (div_mode == rtcev_div_run) && osc_tick && (&cnt_ff);
      end
   end

   assign div_count = cnt_ff;
   assign sec_tick  = sec_ff;
endmodule : rtcev_divider

//--- verilog/rtcev_top.sv
// rtc event and rate logic: divider taps, square wave, periodic, alarm and
// update-ended events, event status with read-to-clear, open-drain request.
// assumes an axi4-lite master on aclk and a calendar that supplies the time bytes.
//
// Notes on behaviour
// - time base divides down to a 1 hz tick starting each update cycle
// - thirteen divider taps feed a 16-to-1 selector for square wave and periodic
// - rate code 0 none, 1-2 give 256/128 hz, 3-15 halve from 8.192 khz
// - each of three events sets its flag; request only when its enable set
// - every request also sets the summary request flag
// - reading event status clears all flags not set or test-written in that same cycle and floats the request output
// - periodic request follows the rate code, 122 us to 500 ms
// - oscillator code 011 leaves periodic timing unchanged
// - update cycle compares hours, minutes, seconds with alarm bytes; match sets flag
// - alarm and request keep working on battery power
// - alarm byte with both top bits set is a wildcard
// - wildcards give alarms per day, hour, minute or second
// - update-ended flag sets at the end of each update cycle
// - update request needs update enable set and transfer inhibit clear
// - update-in-progress reads 0 only with the pre-update interval still ahead
// - next update cycle begins about 998 ms after one ends
// - control bits 6..3 are periodic, alarm, update, square-wave enables; reset clear
// - event status read-only except with oscillator code 011: summary 7, periodic 6, alarm 5, update 4
// - codes 010 and 011 run divider, 11x holds divider, others stop oscillator
`timescale 1ns/1ps
`include "rtcev_regs.svh"

module rtcev_top #(
   parameter int DIV_W         = 15,
   parameter int PRE_UPD_TICKS = `RTCEV_PRE_UPD_TICKS,
   parameter int UPD_LEN_TICKS = `RTCEV_UPD_LEN_TICKS
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   input  wire logic                osc_tick,
   input  wire logic                on_battery,
   input  wire rtcev_pkg::rtcev_byte_t time_sec,
   input  wire rtcev_pkg::rtcev_byte_t time_min,
   input  wire rtcev_pkg::rtcev_byte_t time_hour,
   output rtcev_pkg::rtcev_byte_t   cal_ctrl,
   output logic                     update_start,
   output logic                     square_wave_out,
   output logic                     irq_n_o,
   output logic                     irq_n_oe,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);
   import rtcev_pkg::*;

   localparam logic [DIV_W-1:0] UIP_FROM = DIV_W'((2 ** DIV_W) - PRE_UPD_TICKS);
   localparam logic [7:0]       UPD_LAST = 8'(UPD_LEN_TICKS - 1);

   // register state
   logic [2:0]      osc_control_ff;
   rtcev_rate_t     rate_select_ff;
   rtcev_byte_t     ctrl_b_ff;
   rtcev_byte_t     alm_sec_ff;
   rtcev_byte_t     alm_min_ff;
   rtcev_byte_t     alm_hour_ff;
   logic [3:0]      flags_ff;   // summary, periodic, alarm, update-ended
   // event state
   logic            mux_prev_ff;
   logic            sq_out_ff;
   logic            upd_busy_ff;
   logic [7:0]      upd_cnt_ff;
   logic            upd_start_ff;
   // bus state
   logic            bvalid_ff;
   logic [1:0]      bresp_ff;
   logic            rvalid_ff;
   logic [1:0]      rresp_ff;
   rtcev_byte_t     rdata_ff;

   rtcev_div_mode_t div_mode;
   logic [DIV_W-1:0] div_count;
   logic            sec_tick;
   logic [15:0]     mux_in;
   logic            mux_out;
   logic            osc_run;
   logic            per_evt;
   logic            upd_end;
   logic            alm_match;
   logic            alm_evt;
   logic            in_progress;
   logic [3:0]      evt_set;
   logic            req;
   logic            wr_go;
   logic            rd_go;
   logic [5:0]      widx;
   logic [5:0]      ridx;
   logic            wr_en;
   logic            c_clr;
   logic            c_wr;
   rtcev_byte_t     rd_byte;

   ///////////////////////////////////////////////////////////////////////////
   // helpers

   // divider tap that feeds each selector input
   function automatic int rate_tap(input int code);
      if (code <= 2) begin
         rate_tap = code + 5;
      end else begin
         rate_tap = code - 2;
      end
   endfunction : rate_tap

   // mapped register indices
   function automatic logic idx_mapped(input logic [5:0] idx);
      if (idx <= `RTCEV_IDX_HOUR_ALM) begin
         idx_mapped = 1'b1;
      end else if (idx >= `RTCEV_IDX_A && idx <= `RTCEV_IDX_D) begin
         idx_mapped = 1'b1;
      end else begin
         idx_mapped = 1'b0;
      end
   endfunction : idx_mapped

   // alarm byte equal or wildcard
   function automatic logic alm_ok(input rtcev_byte_t alm, input rtcev_byte_t now);
      alm_ok = (alm[7:6] == `RTCEV_WILD) || (alm == now);
   endfunction : alm_ok

   ///////////////////////////////////////////////////////////////////////////
   // divider and rate selector

   // oscillator control decode
   always_comb begin
      if (osc_control_ff == `RTCEV_OSC_RUN || osc_control_ff == `RTCEV_OSC_RUN_RW) begin
         div_mode = rtcev_div_run;
      end else if (osc_control_ff[2:1] == `RTCEV_OSC_HOLD) begin
         div_mode = rtcev_div_hold;
      end else begin
         div_mode = rtcev_div_stop;
      end
   end

   rtcev_divider #(
      .DIV_W     (DIV_W)
   ) u_divider (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .osc_tick  (osc_tick),
      .div_mode  (div_mode),
      .div_count (div_count),
      .sec_tick  (sec_tick)
   );

   // selector inputs, code zero gives no output
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_tap
         if (g == 0) begin : g_none
            assign mux_in[g] = 1'b0;
         end else begin : g_sel
            assign mux_in[g] = div_count[rate_tap(g)];
         end
      end
   endgenerate

   assign mux_out = mux_in[rate_select_ff];
   assign osc_run = ce && osc_tick && (div_mode == rtcev_div_run);

   // square-wave pin and selector edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sq_out_ff   <= 1'b0;
         mux_prev_ff <= 1'b0;
      end else if (ce) begin
         sq_out_ff   <= ctrl_b_ff[`RTCEV_B_SQ_EN] & mux_out;
         mux_prev_ff <= mux_out;
      end
   end

   // one periodic event per selector period
   assign per_evt = mux_out & ~mux_prev_ff;

   ///////////////////////////////////////////////////////////////////////////
   // update cycle

   // busy from the 1 hz tick for a fixed number of time-base ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upd_busy_ff <= 1'b0;
         upd_cnt_ff  <= 8'h00;
      end else if (ce) begin
         if (sec_tick) begin
            upd_busy_ff <= 1'b1;
            upd_cnt_ff  <= 8'h00;
         end else if (upd_end) begin
            upd_busy_ff <= 1'b0;
         end else if (upd_busy_ff && osc_run) begin
            upd_cnt_ff  <= upd_cnt_ff + 8'h01;
         end
      end
   end

   assign upd_end = upd_busy_ff && osc_run && (upd_cnt_ff == UPD_LAST);

   // start pulse for the calendar logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upd_start_ff <= 1'b0;
      end else if (ce) begin
         upd_start_ff <= sec_tick;
      end
   end

   // in progress from the pre-update window until the cycle ends
   // the tick term covers the wrap cycle, before busy has risen
   assign in_progress = upd_busy_ff || sec_tick || (div_count >= UIP_FROM);

   ///////////////////////////////////////////////////////////////////////////
   // alarm compare at the end of each update, independent of battery state
   assign alm_match = alm_ok(alm_hour_ff, time_hour)
                    & alm_ok(alm_min_ff, time_min)
                    & alm_ok(alm_sec_ff, time_sec);
   assign alm_evt   = upd_end & alm_match;

   ///////////////////////////////////////////////////////////////////////////
   // event flags and request

   assign req = (per_evt & ctrl_b_ff[`RTCEV_B_PER_EN])
              | (alm_evt & ctrl_b_ff[`RTCEV_B_ALM_EN])
              | (upd_end & ctrl_b_ff[`RTCEV_B_UPD_EN] & ~ctrl_b_ff[`RTCEV_B_INHIBIT]);
   assign evt_set = {req, per_evt, alm_evt, upd_end};

   // set wins over a read clear or a test write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_ff <= 4'h0;
      end else if (ce) begin
         for (int i = 0; i < 4; i++) begin
            if (evt_set[i]) begin
               flags_ff[i] <= 1'b1;
            end else if (c_wr) begin
               flags_ff[i] <= s_axi_wdata[`RTCEV_C_UPD + i];
            end else if (c_clr) begin
               flags_ff[i] <= 1'b0;
            end
         end
      end
   end

   // open-drain request, pulled low while the summary flag stands
   assign irq_n_o  = 1'b0;
   assign irq_n_oe = flags_ff[3];

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel, address and data taken together

   assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign widx          = s_axi_awaddr[7:2];
   // supply loss write-protects the registers
   assign wr_en         = wr_go && s_axi_wstrb[0] && !on_battery;
   assign c_wr          = wr_en && (widx == `RTCEV_IDX_C)
                        && (osc_control_ff == `RTCEV_OSC_RUN_RW);

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `RTCEV_RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= idx_mapped(widx) ? `RTCEV_RESP_OKAY : `RTCEV_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // rate and oscillator register, in-progress bit is read-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {osc_control_ff, rate_select_ff} <= `RTCEV_A_RST;
      end else if (ce && wr_en && widx == `RTCEV_IDX_A) begin
         osc_control_ff <= s_axi_wdata[`RTCEV_A_OSC_HI:`RTCEV_A_OSC_LO];
         rate_select_ff <= s_axi_wdata[`RTCEV_A_RATE_HI:0];
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_b_ff <= `RTCEV_B_RST;
      end else if (ce && wr_en && widx == `RTCEV_IDX_B) begin
         ctrl_b_ff <= s_axi_wdata[7:0];
      end
   end

   // alarm bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alm_sec_ff  <= `RTCEV_ALM_RST;
         alm_min_ff  <= `RTCEV_ALM_RST;
         alm_hour_ff <= `RTCEV_ALM_RST;
      end else if (ce && wr_en) begin
         if (widx == `RTCEV_IDX_SEC_ALM) begin
            alm_sec_ff <= s_axi_wdata[7:0];
         end else if (widx == `RTCEV_IDX_MIN_ALM) begin
            alm_min_ff <= s_axi_wdata[7:0];
         end else if (widx == `RTCEV_IDX_HOUR_ALM) begin
            alm_hour_ff <= s_axi_wdata[7:0];
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   assign rd_go         = ce && s_axi_arvalid && !rvalid_ff;
   assign s_axi_arready = rd_go;
   assign ridx          = s_axi_araddr[7:2];
   assign c_clr         = rd_go && (ridx == `RTCEV_IDX_C);

   // read data decode
   always_comb begin
      rd_byte = 8'h00;
      if (ridx == `RTCEV_IDX_SEC) begin
         rd_byte = time_sec;
      end else if (ridx == `RTCEV_IDX_SEC_ALM) begin
         rd_byte = alm_sec_ff;
      end else if (ridx == `RTCEV_IDX_MIN) begin
         rd_byte = time_min;
      end else if (ridx == `RTCEV_IDX_MIN_ALM) begin
         rd_byte = alm_min_ff;
      end else if (ridx == `RTCEV_IDX_HOUR) begin
         rd_byte = time_hour;
      end else if (ridx == `RTCEV_IDX_HOUR_ALM) begin
         rd_byte = alm_hour_ff;
      end else if (ridx == `RTCEV_IDX_A) begin
         rd_byte = {in_progress, osc_control_ff, rate_select_ff};
      end else if (ridx == `RTCEV_IDX_B) begin
         rd_byte = ctrl_b_ff;
      end else if (ridx == `RTCEV_IDX_C) begin
         rd_byte = {flags_ff, 4'h0};
      end else if (ridx == `RTCEV_IDX_D) begin
         rd_byte = `RTCEV_D_VAL;
      end
   end

   // read response, data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= `RTCEV_RESP_OKAY;
         rdata_ff  <= 8'h00;
      end else if (ce) begin
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_byte;
            rresp_ff  <= idx_mapped(ridx) ? `RTCEV_RESP_OKAY : `RTCEV_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_bvalid    = bvalid_ff;
   assign s_axi_bresp     = bresp_ff;
   assign s_axi_rvalid    = rvalid_ff;
   assign s_axi_rresp     = rresp_ff;
   assign s_axi_rdata     = {24'h000000, rdata_ff};
   assign square_wave_out = sq_out_ff;
   assign update_start    = upd_start_ff;
   assign cal_ctrl        = ctrl_b_ff;
endmodule : rtcev_top

//--- test/rtcev_sva.sv
// port checker for the rtc event block
// assumes it is bound to rtcev_top and sees only that module's ports
`timescale 1ns/1ps

module rtcev_sva (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire logic                   ce,
   input wire rtcev_pkg::rtcev_byte_t cal_ctrl,
   input wire logic                   update_start,
   input wire logic                   square_wave_out,
   input wire logic                   irq_n_o,
   input wire logic                   irq_n_oe,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [7:0]             s_axi_araddr,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready
);
   import rtcev_pkg::*;

   // all checks on the single clock domain
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////
   // request pin, square wave and update start
   a_irq_data_low: assert property (irq_n_o == 1'h0)
      else $error("request pin data not low");
   a_irq_read_clear: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == 8'h30 && cal_ctrl[6:4] == 3'h0 |=> !irq_n_oe)
      else $error("request not released after status read");
   a_square_disabled: assert property (!cal_ctrl[3] && !$past(cal_ctrl[3])
      |-> !square_wave_out)
      else $error("square wave active while disabled");
   a_tick_pulse: assert property (update_start |=> !update_start)
      else $error("update start longer than one cycle");

   // register bus answers
   a_wr_ready: assert property (s_axi_awready |->
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && ce)
      else $error("write accepted without both channels");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule : rtcev_sva

bind rtcev_top rtcev_sva i_rtcev_sva (.aclk, .aresetn, .ce, .cal_ctrl, .update_start,
   .square_wave_out, .irq_n_o, .irq_n_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

//--- test/rtcev_bench.sv
// self-checking bench for the rtc event block
// assumes rtcev_top; the time base ticks every other clock
`timescale 1ns/1ps

module rtcev_bench;
   import rtcev_pkg::*;

   logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, osc_tick = 1'h0, on_battery = 1'h0;
   rtcev_byte_t time_sec = 8'h05, time_min = 8'h34, time_hour = 8'h12, cal_ctrl;
   logic        update_start, square_wave_out, irq_n_o, irq_n_oe;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          err_total = 0, check_count = 0;

   rtcev_top i_rtcev_top (.aclk, .aresetn, .ce, .osc_tick, .on_battery, .time_sec, .time_min,
      .time_hour, .cal_ctrl, .update_start, .square_wave_out, .irq_n_o, .irq_n_oe,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   // clock and a time-base pulse every other cycle
   always #5 aclk = ~aclk;
   always @(posedge aclk) osc_tick <= ~osc_tick;

   ////////////////////////////////////////////////////////////
   // reporting and bounded waits
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   function automatic logic pick(input int k);
      case (k)
         0: return s_axi_awready;
         2: return s_axi_arready;
         3: return s_axi_rvalid;
         4: return irq_n_oe;
         5: return update_start;
         default: return s_axi_bvalid;
      endcase
   endfunction : pick

   task automatic wait_hi(input int k, input int lim);
      int n;
      @(negedge aclk);
      for (n = 0; n < lim && pick(k) !== 1'h1; n++) @(negedge aclk);
      if (n >= lim) begin
         chk(n, 0);
         wrap_up();
      end
   endtask : wait_hi

   // bus cycles, payload held until taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      wait_hi(0, 50);
      @(posedge aclk);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      wait_hi(1, 50);
      chk(s_axi_bresp, 2'h0);
      @(posedge aclk);
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      wait_hi(2, 50);
      @(posedge aclk);
      s_axi_arvalid <= 1'h0;
      wait_hi(3, 50);
      chk({s_axi_rdata[31:8], s_axi_rdata[7:0] & m, s_axi_rresp}, {24'h0, e, er});
      @(posedge aclk);
      s_axi_rready <= 1'h0;
   endtask : rd_chk

   // counts square-wave rises; t2 marks the second one
   task automatic sq_edges(input int lim, output int k, output int t2, output int n);
      logic p;
      k = 0;
      t2 = 0;
      p = square_wave_out;
      for (n = 0; n < lim && k < 3; n++) begin
         @(negedge aclk);
         if (square_wave_out === 1'h1 && p === 1'h0) k++;
         if (k == 2 && t2 == 0) t2 = n + 1;
         p = square_wave_out;
      end
   endtask : sq_edges

   ////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_regs();
      rd_chk(8'h2c, 8'hff, 8'h00, 2'h0);
      rd_chk(8'h30, 8'hff, 8'h00, 2'h0);
      rd_chk(8'h34, 8'hff, 8'h80, 2'h0);
      rd_chk(8'h18, 8'h00, 8'h00, 2'h2);
      wr(8'h30, 8'hf0);
      rd_chk(8'h30, 8'hff, 8'h00, 2'h0);
      wr(8'h2c, 8'h78);
      chk(cal_ctrl, 8'h78);
      on_battery <= 1'h1;
      wr(8'h2c, 8'h00);
      on_battery <= 1'h0;
      rd_chk(8'h2c, 8'hff, 8'h78, 2'h0);
   endtask : t_regs

   task automatic t_rates();
      int k, t2, n, e;
      wr(8'h2c, 8'h08);
      wr(8'h28, 8'h20);
      sq_edges(300, k, t2, n);
      chk(k, 0);
      for (int c = 1; c < 13; c++) begin
         e = (c < 3) ? (2 << (c + 6)) : (2 << (c - 1));
         wr(8'h28, 8'h20 | c[7:0]);
         sq_edges(4 * e + 20, k, t2, n);
         chk(k == 3 ? n - t2 : 0, e);
      end
      wr(8'h28, 8'h33);
      sq_edges(60, k, t2, n);
      chk(k == 3 ? n - t2 : 0, 8);
      // clock enable low freezes the selector and the pin
      @(posedge aclk);
      ce <= 1'h0;
      @(negedge aclk);
      sq_edges(60, k, t2, n);
      @(posedge aclk);
      ce <= 1'h1;
      chk(k, 0);
      wr(8'h2c, 8'h00);
      sq_edges(60, k, t2, n);
      chk(k, 0);
   endtask : t_rates

   task automatic t_periodic();
      wr(8'h28, 8'h23);
      rd_chk(8'h30, 8'h00, 8'h00, 2'h0);
      repeat (30) @(negedge aclk);
      chk(irq_n_oe, 1'h0);
      rd_chk(8'h30, 8'hff, 8'h40, 2'h0);
      wr(8'h2c, 8'h40);
      wait_hi(4, 40);
      rd_chk(8'h08, 8'hff, 8'h34, 2'h0);
      wr(8'h2c, 8'h00);
      rd_chk(8'h30, 8'hcf, 8'hc0, 2'h0);
      wr(8'h28, 8'h20);
      rd_chk(8'h30, 8'h00, 8'h00, 2'h0);
      repeat (3) @(negedge aclk);
      chk(irq_n_oe, 1'h0);
      rd_chk(8'h30, 8'hff, 8'h00, 2'h0);
   endtask : t_periodic

   task automatic t_update();
      wr(8'h04, 8'h05);
      wr(8'h0c, 8'h34);
      wr(8'h14, 8'hc0);
      wr(8'h2c, 8'h30);
      on_battery <= 1'h1;
      wait_hi(5, 70000);
      rd_chk(8'h28, 8'hff, 8'ha0, 2'h0);
      wait_hi(4, 400);
      rd_chk(8'h30, 8'hff, 8'hb0, 2'h0);
      rd_chk(8'h00, 8'hff, 8'h05, 2'h0);
      rd_chk(8'h28, 8'hff, 8'h20, 2'h0);
      on_battery <= 1'h0;
   endtask : t_update

   // main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_rates();
      t_periodic();
      t_update();
      wrap_up();
   end
endmodule : rtcev_bench
